/* File: hw/pmi_regs.svh */
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH

// Reference clock and bit durations
`define PMI_REF_PERIOD_NS 10
`define PMI_BIT100_NS 10
`define PMI_BIT10_NS 100

// Interface clock periods
`define PMI_CLK100_PERIOD_NS 40
`define PMI_CLK10MII_PERIOD_NS 400
`define PMI_CLK10SER_PERIOD_NS 100

// Derived cycle counts
`define PMI_CLK100_CYC (`PMI_CLK100_PERIOD_NS / `PMI_REF_PERIOD_NS)
`define PMI_CLK10MII_CYC (`PMI_CLK10MII_PERIOD_NS / `PMI_REF_PERIOD_NS)
`define PMI_CLK10SER_CYC (`PMI_CLK10SER_PERIOD_NS / `PMI_REF_PERIOD_NS)
`define PMI_BIT100_CYC (`PMI_BIT100_NS / `PMI_REF_PERIOD_NS)
`define PMI_BIT10_CYC (`PMI_BIT10_NS / `PMI_REF_PERIOD_NS)
`define PMI_RX_SAMPLE_OFS (`PMI_BIT10_CYC / 2)

// Mode strap encodings
`define PMI_STRAP_MII100 2'h0
`define PMI_STRAP_SYM100 2'h1
`define PMI_STRAP_MII10 2'h2
`define PMI_STRAP_SER10 2'h3

// Line symbols, first transmitted bit in bit 0
`define PMI_SYM_J 5'h03
`define PMI_SYM_K 5'h11
`define PMI_SYM_T 5'h16
`define PMI_SYM_R 5'h1C
`define PMI_SYM_H 5'h04
`define PMI_SYM_LEN 4'h5
`define PMI_NIB_LEN 4'h4
`define PMI_BIT_LEN 4'h1
`define PMI_JK_LEN 4'hA
`define PMI_TR_LEN 4'hA

// Transmit buffer
`define PMI_TXBUF_WIDTH 7
`define PMI_TXBUF_DEPTH 4
`define PMI_TXE_SINGLE 6
`define PMI_TXE_ER 5
`define PMI_TXE_EN 4

// Management frame
`define PMI_MDIO_PRE_LEN 6'h20
`define PMI_MDIO_HDR_LAST 4'hB
`define PMI_MDIO_DATA_LAST 4'hF
`define PMI_MDIO_OP_READ 2'h2
`define PMI_PHY_ADDR_DEF 5'h01

`endif

/* File: hw/pmi_pkg.sv */
package pmi_pkg;

  typedef enum logic [1:0] {
    PMI_MII100,
    PMI_SYM100,
    PMI_MII10,
    PMI_SER10
  } pmi_mode_e;

  typedef enum logic [2:0] {
    PMI_MG_PRE,
    PMI_MG_ST,
    PMI_MG_HDR,
    PMI_MG_TA,
    PMI_MG_DATA,
    PMI_MG_REL
  } pmi_mgmt_e;

endpackage

/* File: hw/pmi_fifo.sv */
`timescale 1ns/1ps
`include "pmi_regs.svh"

module pmi_fifo
  import pmi_pkg::*;
#(
  parameter int WIDTH = `PMI_TXBUF_WIDTH,
  parameter int DEPTH = `PMI_TXBUF_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (inValid && !full)
    begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
    end
    else if (inValid && !full)
    begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdPtr_r <= '0;
    end
    else if (outReady && !empty)
    begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

endmodule

/* File: hw/pmi_mac_side.sv */
`timescale 1ns/1ps
`include "pmi_regs.svh"

module pmi_mac_side
  import pmi_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PMI_PHY_ADDR_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] modeSel,
  input wire logic fullDuplex,
  output logic txClk,
  input wire logic [3:0] txd,
  input wire logic txEn,
  input wire logic txEr,
  output logic txBufReady,
  output logic rxClk,
  output logic [3:0] rxd,
  output logic rxDv,
  output logic rxEr,
  output logic carrierSense,
  output logic serial_tx_clock,
  input wire logic serial_tx_data,
  input wire logic serial_tx_enable,
  output logic serial_rx_clock,
  output logic serial_rx_data,
  output logic line_tx_pair,
  output logic lineTxActive,
  input wire logic line_rx_pair,
  input wire logic lineRxValid,
  input wire logic lineRxError,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN
);

  // Interface clock period per mode
  function automatic logic [5:0] periodOf(input pmi_mode_e m);
    case (m)
      PMI_MII100, PMI_SYM100: periodOf = 6'(`PMI_CLK100_CYC);
      PMI_MII10: periodOf = 6'(`PMI_CLK10MII_CYC);
      default: periodOf = 6'(`PMI_CLK10SER_CYC);
    endcase
  endfunction

  // Strap synchronisers and mode decode
  logic [1:0] modeS1_r;
  logic [1:0] modeS2_r;
  logic dupS1_r;
  logic dupS2_r;
  pmi_mode_e mode_r;
  logic is100;
  logic isSer;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      modeS1_r <= `PMI_STRAP_MII100;
      modeS2_r <= `PMI_STRAP_MII100;
      dupS1_r <= 1'b0;
      dupS2_r <= 1'b0;
      mode_r <= PMI_MII100;
    end
    else
    begin
      modeS1_r <= modeSel;
      modeS2_r <= modeS1_r;
      dupS1_r <= fullDuplex;
      dupS2_r <= dupS1_r;
      case (modeS2_r)
        `PMI_STRAP_MII100: mode_r <= PMI_MII100;
        `PMI_STRAP_SYM100: mode_r <= PMI_SYM100;
        `PMI_STRAP_MII10: mode_r <= PMI_MII10;
        default: mode_r <= PMI_SER10;
      endcase
    end
  end

  assign is100 = (mode_r == PMI_MII100) || (mode_r == PMI_SYM100);
  assign isSer = (mode_r == PMI_SER10);

  logic [5:0] period;
  logic [5:0] half;
  assign period = periodOf(mode_r);
  assign half = period >> 1;

  // Transmit clock and sampling
  logic [5:0] txCnt_r;
  logic [5:0] txCntNxt;
  logic txSample;
  logic txEnPrev_r;
  logic txEnNow;
  logic push;
  logic [`PMI_TXBUF_WIDTH-1:0] txEntry;

  assign txSample = (txCnt_r >= period - 6'h01);
  assign txCntNxt = txSample ? 6'h00 : txCnt_r + 6'h01;
  assign txEnNow = isSer ? serial_tx_enable : txEn;
  assign push = txSample && (txEnNow || txEnPrev_r);
  assign txEntry = isSer ? {1'b1, 1'b0, serial_tx_enable, 3'h0, serial_tx_data}
                         : {1'b0, txEr, txEn, txd};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      txCnt_r <= 6'h00;
      txClk <= 1'b0;
      serial_tx_clock <= 1'b0;
    end
    else
    begin
      txCnt_r <= txCntNxt;
      txClk <= !isSer && (txCntNxt < half);
      serial_tx_clock <= isSer && (txCntNxt < half);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      txEnPrev_r <= 1'b0;
    end
    else if (txSample)
    begin
      txEnPrev_r <= txEnNow;
    end
  end

  // Transmit buffer
  logic bufValid;
  logic bufPop;
  logic [`PMI_TXBUF_WIDTH-1:0] bufData;

  pmi_fifo #(
    .WIDTH(`PMI_TXBUF_WIDTH),
    .DEPTH(`PMI_TXBUF_DEPTH)
  ) txBuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(push),
    .inReady(txBufReady),
    .inData(txEntry),
    .outValid(bufValid),
    .outReady(bufPop),
    .outData(bufData)
  );

  // Line serializer
  logic [14:0] shift_r;
  logic [3:0] bitsLeft_r;
  logic [3:0] lineCnt_r;
  logic inFrame_r;
  logic [3:0] bitPer;
  logic lineTick;
  logic [14:0] ldVec;
  logic [3:0] ldLen;
  logic [4:0] dataSym;
  logic [3:0] dataLen;

  assign bitPer = is100 ? 4'(`PMI_BIT100_CYC) : 4'(`PMI_BIT10_CYC);
  assign lineTick = (lineCnt_r == 4'h0);
  assign bufPop = lineTick && (bitsLeft_r == 4'h0) && bufValid;

  always_comb
  begin
    ldVec = '0;
    ldLen = 4'h0;
    dataSym = bufData[`PMI_TXE_ER] ? `PMI_SYM_H : {1'b0, bufData[3:0]};
    dataLen = bufData[`PMI_TXE_ER] ? `PMI_SYM_LEN : `PMI_NIB_LEN;
    if (mode_r == PMI_MII100)
    begin
      if (!bufData[`PMI_TXE_EN])
      begin
        ldVec = {5'h00, `PMI_SYM_R, `PMI_SYM_T};
        ldLen = inFrame_r ? `PMI_TR_LEN : 4'h0;
      end
      else if (!inFrame_r)
      begin
        ldVec = {dataSym, `PMI_SYM_K, `PMI_SYM_J};
        ldLen = `PMI_JK_LEN + dataLen;
      end
      else
      begin
        ldVec = {10'h000, dataSym};
        ldLen = dataLen;
      end
    end
    else if (bufData[`PMI_TXE_EN])
    begin
      ldVec = {11'h000, bufData[3:0]};
      ldLen = bufData[`PMI_TXE_SINGLE] ? `PMI_BIT_LEN : `PMI_NIB_LEN;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
      bitsLeft_r <= 4'h0;
      lineCnt_r <= 4'h0;
      inFrame_r <= 1'b0;
      line_tx_pair <= 1'b0;
      lineTxActive <= 1'b0;
    end
    else if (!lineTick)
    begin
      lineCnt_r <= lineCnt_r - 4'h1;
    end
    else if (bitsLeft_r != 4'h0)
    begin
      line_tx_pair <= shift_r[0];
      shift_r <= shift_r >> 1;
      bitsLeft_r <= bitsLeft_r - 4'h1;
      lineTxActive <= 1'b1;
      lineCnt_r <= bitPer - 4'h1;
    end
    else if (bufValid && (ldLen != 4'h0))
    begin
      line_tx_pair <= ldVec[0];
      shift_r <= ldVec >> 1;
      bitsLeft_r <= ldLen - 4'h1;
      lineTxActive <= 1'b1;
      lineCnt_r <= bitPer - 4'h1;
      inFrame_r <= bufData[`PMI_TXE_EN];
    end
    else
    begin
      inFrame_r <= bufValid ? bufData[`PMI_TXE_EN] : inFrame_r;
      line_tx_pair <= 1'b0;
      lineTxActive <= 1'b0;
    end
  end

  // Receive input synchronisers
  logic rxDS1_r;
  logic rxDS2_r;
  logic rxVS1_r;
  logic rxVS2_r;
  logic rxES1_r;
  logic rxES2_r;
  logic rxVPrev_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxDS1_r <= 1'b0;
      rxDS2_r <= 1'b0;
      rxVS1_r <= 1'b0;
      rxVS2_r <= 1'b0;
      rxES1_r <= 1'b0;
      rxES2_r <= 1'b0;
      rxVPrev_r <= 1'b0;
    end
    else
    begin
      rxDS1_r <= line_rx_pair;
      rxDS2_r <= rxDS1_r;
      rxVS1_r <= lineRxValid;
      rxVS2_r <= rxVS1_r;
      rxES1_r <= lineRxError;
      rxES2_r <= rxES1_r;
      rxVPrev_r <= rxVS2_r;
    end
  end

  // Receive clock, realigned at frame start in the 10M modes
  logic rxStart;
  logic [5:0] rxCnt_r;
  logic [5:0] effCnt;
  logic [5:0] rxCntNxt;
  logic outEdge;
  logic [3:0] rxSub_r;
  logic [3:0] effSub;
  logic [1:0] rxIdx_r;
  logic [1:0] effIdx;
  logic rxSamp;
  logic [3:0] asm_r;
  logic [3:0] asmNxt;
  logic rxBit_r;
  logic errAcc_r;
  logic rxFrame_r;
  logic frameNow;

  // 100M frames are delayed onto the free-running nibble grid
  logic rawStart;
  logic [1:0] tap_r;
  logic [1:0] tapNow;
  logic [3:0] vHist_r;
  logic [2:0] dHist_r;
  logic [2:0] eHist_r;
  logic [5:0] vVec;
  logic [3:0] dVec;
  logic [3:0] eVec;
  logic selV;
  logic selVPrev;
  logic selVNext;
  logic selD;
  logic selE;

  assign rawStart = rxVS2_r && !rxVPrev_r && !rxFrame_r;
  assign tapNow = !rawStart ? tap_r : (is100 ? 2'(6'h00 - rxCnt_r) : 2'h0);
  assign vVec = {vHist_r, rxVS2_r, rxVS1_r};
  assign dVec = {dHist_r, rxDS2_r};
  assign eVec = {eHist_r, rxES2_r};
  assign selVNext = vVec[3'(tapNow)];
  assign selV = vVec[3'(tapNow) + 3'h1];
  assign selVPrev = vVec[3'(tapNow) + 3'h2];
  assign selD = dVec[tapNow];
  assign selE = eVec[tapNow];
  assign rxStart = selV && !selVPrev;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tap_r <= 2'h0;
      vHist_r <= 4'h0;
      dHist_r <= 3'h0;
      eHist_r <= 3'h0;
    end
    else
    begin
      tap_r <= tapNow;
      vHist_r <= {vHist_r[2:0], rxVS2_r};
      dHist_r <= {dHist_r[1:0], rxDS2_r};
      eHist_r <= {eHist_r[1:0], rxES2_r};
    end
  end
  assign effCnt = rxStart ? 6'h00 : rxCnt_r;
  assign outEdge = (effCnt >= period - 6'h01);
  assign rxCntNxt = outEdge ? 6'h00 : effCnt + 6'h01;
  assign effSub = rxStart ? 4'h0 : rxSub_r;
  assign effIdx = rxStart ? 2'h0 : rxIdx_r;
  assign rxSamp = is100 || (effSub == 4'(`PMI_RX_SAMPLE_OFS));
  assign frameNow = rxFrame_r || rxStart;

  always_comb
  begin
    asmNxt = asm_r;
    if (rxSamp)
    begin
      asmNxt[effIdx] = selD;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxCnt_r <= 6'h00;
      rxSub_r <= 4'h0;
      rxIdx_r <= 2'h0;
      rxClk <= 1'b0;
      serial_rx_clock <= 1'b0;
    end
    else
    begin
      rxCnt_r <= rxCntNxt;
      rxSub_r <= (effSub >= 4'(`PMI_BIT10_CYC) - 4'h1) ? 4'h0 : effSub + 4'h1;
      rxIdx_r <= rxSamp ? effIdx + 2'h1 : effIdx;
      rxClk <= !isSer && (rxCntNxt >= half);
      serial_rx_clock <= isSer && (rxCntNxt >= half);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      asm_r <= 4'h0;
      rxBit_r <= 1'b0;
      errAcc_r <= 1'b0;
      rxFrame_r <= 1'b0;
    end
    else
    begin
      asm_r <= outEdge ? 4'h0 : asmNxt;
      rxBit_r <= rxSamp ? selD : rxBit_r;
      errAcc_r <= !outEdge && (errAcc_r || (rxSamp && selE));
      rxFrame_r <= outEdge ? (frameNow && selVNext) : frameNow;
    end
  end

  // Receive outputs change as the receive clock falls
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxd <= 4'h0;
      rxDv <= 1'b0;
      rxEr <= 1'b0;
      serial_rx_data <= 1'b0;
    end
    else if (outEdge)
    begin
      rxd <= (frameNow && !isSer) ? asmNxt : 4'h0;
      rxDv <= frameNow && !isSer;
      rxEr <= frameNow && !isSer && (errAcc_r || (rxSamp && selE));
      serial_rx_data <= frameNow && isSer && rxBit_r;
    end
  end

  // Carrier sense
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      carrierSense <= 1'b0;
    end
    else
    begin
      carrierSense <= (!dupS2_r && txEnNow) || rxFrame_r;
    end
  end

  // Status word handed to the management domain
  logic [15:0] statusNow;
  logic [15:0] stHold_r;
  logic stReq_r;
  logic ackS1_r;
  logic ackS2_r;
  logic ackM_r;

  assign statusNow = {10'h000, mode_r, dupS2_r, lineTxActive, rxFrame_r, carrierSense};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stHold_r <= 16'h0000;
      stReq_r <= 1'b0;
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
    end
    else
    begin
      ackS1_r <= ackM_r;
      ackS2_r <= ackS1_r;
      if (ackS2_r == stReq_r)
      begin
        stHold_r <= statusNow;
        stReq_r <= !stReq_r;
      end
    end
  end

  // Management serial port on MDC
  pmi_mgmt_e mgSt_r;
  logic reqS1_r;
  logic reqS2_r;
  logic [15:0] stMdc_r;
  logic [15:0] word_r;
  logic [5:0] preCnt_r;
  logic [3:0] bitCnt_r;
  logic [10:0] hdr_r;
  logic [11:0] hdrFull;

  assign hdrFull = {hdr_r, mdioIn};

  always_ff @(posedge mdc or posedge rst)
  begin
    if (rst)
    begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      ackM_r <= 1'b0;
      stMdc_r <= 16'h0000;
    end
    else
    begin
      reqS1_r <= stReq_r;
      reqS2_r <= reqS1_r;
      if (reqS2_r != ackM_r)
      begin
        stMdc_r <= stHold_r;
        ackM_r <= reqS2_r;
      end
    end
  end

  always_ff @(posedge mdc or posedge rst)
  begin
    if (rst)
    begin
      mgSt_r <= PMI_MG_PRE;
      preCnt_r <= 6'h00;
      bitCnt_r <= 4'h0;
      hdr_r <= '0;
      word_r <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOeN <= 1'b1;
    end
    else
    begin
      case (mgSt_r)
        PMI_MG_PRE:
        begin
          if (mdioIn)
          begin
            preCnt_r <= (preCnt_r == `PMI_MDIO_PRE_LEN) ? preCnt_r : preCnt_r + 6'h01;
          end
          else
          begin
            mgSt_r <= (preCnt_r == `PMI_MDIO_PRE_LEN) ? PMI_MG_ST : PMI_MG_PRE;
            preCnt_r <= 6'h00;
          end
        end
        PMI_MG_ST:
        begin
          mgSt_r <= mdioIn ? PMI_MG_HDR : PMI_MG_PRE;
          bitCnt_r <= 4'h0;
        end
        PMI_MG_HDR:
        begin
          hdr_r <= hdrFull[10:0];
          bitCnt_r <= bitCnt_r + 4'h1;
          if (bitCnt_r == `PMI_MDIO_HDR_LAST)
          begin
            if ((hdrFull[11:10] == `PMI_MDIO_OP_READ) && (hdrFull[9:5] == PHY_ADDR))
            begin
              mgSt_r <= PMI_MG_TA;
            end
            else
            begin
              mgSt_r <= PMI_MG_PRE;
            end
          end
        end
        PMI_MG_TA:
        begin
          mdioOeN <= 1'b0;
          mdioOut <= 1'b0;
          word_r <= stMdc_r;
          bitCnt_r <= `PMI_MDIO_DATA_LAST;
          mgSt_r <= PMI_MG_DATA;
        end
        PMI_MG_DATA:
        begin
          mdioOut <= word_r[bitCnt_r];
          bitCnt_r <= bitCnt_r - 4'h1;
          mgSt_r <= (bitCnt_r == 4'h0) ? PMI_MG_REL : PMI_MG_DATA;
        end
        PMI_MG_REL:
        begin
          mdioOeN <= 1'b1;
          mdioOut <= 1'b0;
          preCnt_r <= mdioIn ? 6'h01 : 6'h00;
          mgSt_r <= PMI_MG_PRE;
        end
        default:
        begin
          mgSt_r <= PMI_MG_PRE;
        end
      endcase
    end
  end

endmodule

/* File: verif/pmi_mac_side_chk.sv */
`timescale 1ns/1ps
module pmi_mac_side_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] modeSel,
  input wire logic fullDuplex,
  input wire logic txClk,
  input wire logic txEn,
  input wire logic rxClk,
  input wire logic [3:0] rxd,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic carrierSense,
  input wire logic serial_tx_clock,
  input wire logic serial_tx_enable,
  input wire logic line_tx_pair,
  input wire logic lineTxActive,
  input wire logic lineRxValid,
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOeN
);
  logic [3:0] upCnt_r;
  logic up;
  logic half;
  assign up = upCnt_r == 4'hF;
  assign half = up && !fullDuplex && !lineRxValid;
  // Straps settle after reset
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      upCnt_r <= 4'h0;
    else if (!up)
      upCnt_r <= upCnt_r + 4'h1;

  chk_rxclk_high: assert property (@(posedge ref_clk) disable iff (rst)
    (up && modeSel <= 2'h1 && rxClk) ##1 rxClk |=> !rxClk) else $error("rx clock high long");
  chk_rxclk_low: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel <= 2'h1 && $fell(rxClk) |=> !rxClk) else $error("rx clock low short");
  chk_rx_stable: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(rxClk) |-> $stable({rxd, rxDv, rxEr}) ##1 $stable({rxd, rxDv, rxEr}))
    else $error("rx data moved at clock rise");
  chk_cs_on100: assert property (@(posedge ref_clk) disable iff (rst)
    half && modeSel == 2'h0 && $rose(txEn) |-> ##[0:4] carrierSense) else $error("cs on late");
  chk_cs_off100: assert property (@(posedge ref_clk) disable iff (rst)
    half && modeSel == 2'h0 && $fell(txEn) |-> ##[0:4] !carrierSense) else $error("cs off late");
  chk_cs_on10: assert property (@(posedge ref_clk) disable iff (rst)
    half && modeSel == 2'h2 && $rose(txEn) |-> ##[0:20] carrierSense) else $error("cs on late");
  chk_cs_off10: assert property (@(posedge ref_clk) disable iff (rst)
    half && modeSel == 2'h2 && $fell(txEn) |-> ##[0:40] !carrierSense) else $error("cs off late");
  chk_j_lat: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel == 2'h0 && $rose(txClk) && $past(txEn) && !$past(txEn, 5) && !lineTxActive
    |-> ##[0:3] lineTxActive && line_tx_pair) else $error("start code late");
  chk_sym_lat: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel == 2'h1 && $rose(txClk) && $past(txEn) && !$past(txEn, 5) && !lineTxActive
    |-> ##[0:7] lineTxActive) else $error("symbol tx late");
  chk_mii10_lat: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel == 2'h2 && $rose(txClk) && $past(txEn) && !$past(txEn, 41) && !lineTxActive
    |-> ##[0:20] lineTxActive) else $error("10M tx late");
  chk_ser_lat: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel == 2'h3 && $rose(serial_tx_clock) && $past(serial_tx_enable)
    && !$past(serial_tx_enable, 11) |-> ##[0:10] lineTxActive) else $error("serial tx late");
  chk_rx10_lat: assert property (@(posedge ref_clk) disable iff (rst)
    up && modeSel == 2'h2 && $rose(lineRxValid) |-> ##[1:70] rxDv) else $error("10M rx late");
  chk_mdio_read: assert property (@(posedge mdc) disable iff (rst)
    $fell(mdioOeN) |-> !mdioOut ##1 !mdioOeN[*8] ##1 !mdioOeN[*8] ##1 mdioOeN)
    else $error("mdio read frame");
endmodule

bind pmi_mac_side pmi_mac_side_chk u_chk (.*);

/* File: verif/pmi_mac_model.sv */
`timescale 1ns/1ps
module pmi_mac_model
(
  input wire logic ref_clk,
  input wire logic xClk,
  output logic [3:0] txd,
  output logic txEn,
  output logic txEr
);
  logic [5:0] q[$];
  logic prev;
  initial
  begin
    txd = 4'h0;
    txEn = 1'b0;
    txEr = 1'b0;
    prev = 1'b0;
  end
  // New sample just after each clock rise, held to the next
  always @(posedge ref_clk)
  begin
    if (xClk && !prev)
      {txEr, txEn, txd} <= #1 (q.size() > 0) ? q.pop_front() : {2'b00, ~txd};
    prev <= xClk;
  end
endmodule

/* File: verif/tb_pmi_mac_side.sv */
`timescale 1ns/1ps
`include "pmi_regs.svh"
module tb_pmi_mac_side;
  logic ref_clk, rst, fullDuplex, line_rx_pair, lineRxValid, lineRxError, mdc, staOe, staBit;
  logic txEn, txEr, txClk, rxClk, rxDv, rxEr, serial_tx_clock, line_tx_pair, lineTxActive;
  logic mdioOut, mdioOeN, txBufReady, serRxClk, serRxData;
  logic sq[$];
  logic [1:0] modeSel;
  logic [3:0] txd, rxd;
  logic [15:0] rd;
  logic q[$], e[$];
  logic [4:0] rq[$];
  int errors, n_tests;
  wire mdioIn = !mdioOeN ? mdioOut : (staOe ? staBit : 1'b1);

  pmi_mac_side uut (.ref_clk, .rst, .modeSel, .fullDuplex, .txClk, .txd, .txEn, .txEr,
    .txBufReady, .rxClk, .rxd, .rxDv, .rxEr, .carrierSense(), .serial_tx_clock,
    .serial_tx_data(txd[0]), .serial_tx_enable(txEn), .serial_rx_clock(serRxClk),
    .serial_rx_data(serRxData),
    .line_tx_pair, .lineTxActive, .line_rx_pair, .lineRxValid, .lineRxError, .mdc, .mdioIn,
    .mdioOut, .mdioOeN);
  pmi_mac_model mac (.ref_clk, .xClk(modeSel == 2'h3 ? serial_tx_clock : txClk), .txd, .txEn,
    .txEr);

  always @(posedge rxClk)
    if (rxDv)
      rq.push_back({rxEr, rxd});

  always @(posedge serRxClk)
    sq.push_back(serRxData);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic init(input logic [1:0] m, input logic fd);
    rst = 1'b1;
    modeSel = m;
    fullDuplex = fd;
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    q.delete();
    e.delete();
    rq.delete();
    sq.delete();
    chk("bufReady", 16'(txBufReady), 16'h0001);
  endtask

  task automatic addBits(input logic [4:0] v, input int n);
    for (int i = 0; i < n; i++)
      e.push_back(v[i]);
  endtask

  // Line bits sampled mid-bit while active, then compared
  task automatic capTx(input string name, input int per);
    int k;
    k = 0;
    while (!lineTxActive && k < 200)
    begin
      @(posedge ref_clk);
      #1 k++;
    end
    repeat (per / 2) @(posedge ref_clk);
    #1;
    while (lineTxActive && k < 2000)
    begin
      q.push_back(line_tx_pair);
      repeat (per) @(posedge ref_clk);
      #1 k++;
    end
    chk(name, 16'(q.size()), 16'(e.size()));
    foreach (e[i])
      chk(name, 16'(q[i]), 16'(e[i]));
  endtask

  task automatic lineRx(input logic [15:0] bits, input int nb, input int per, input int errNib);
    lineRxValid = 1'b1;
    for (int i = 0; i < nb; i++)
    begin
      line_rx_pair = bits[i];
      lineRxError = (i / 4 == errNib);
      repeat (per) @(posedge ref_clk);
      #1;
    end
    lineRxValid = 1'b0;
    lineRxError = 1'b0;
    line_rx_pair = ~line_rx_pair;
    repeat (100) @(posedge ref_clk);
    #1;
  endtask

  task automatic rxCheck(input logic [19:0] exp, input int n);
    chk("rxCount", 16'(rq.size()), 16'(n));
    for (int i = 0; i < n; i++)
      chk("rxNibble", 16'(rq[i]), 16'(exp[5 * i +: 5]));
  endtask

  task automatic mgmtRead(input logic [4:0] phy);
    logic [45:0] hdr;
    hdr = {32'hFFFF_FFFF, 4'h6, phy, 5'h00};
    for (int i = 0; i < 66; i++)
    begin
      mdc = 1'b0;
      staOe = i < 46;
      staBit = hdr[45];
      hdr = hdr << 1;
      #200 mdc = 1'b1;
      #190;
      if (i >= 47 && i < 63)
        rd = {rd[14:0], mdioIn};
      #10;
    end
    mdc = 1'b0;
    staOe = 1'b0;
  endtask

  task automatic txMii100;
    init(2'h0, 1'b0);
    mac.q = '{6'h15, 6'h1D, 6'h3A, 6'h00};
    addBits(`PMI_SYM_J, 5);
    addBits(`PMI_SYM_K, 5);
    addBits(5'h05, 4);
    addBits(5'h0D, 4);
    addBits(`PMI_SYM_H, 5);
    addBits(`PMI_SYM_T, 5);
    addBits(`PMI_SYM_R, 5);
    capTx("tx100", 1);
  endtask

  task automatic txSym100;
    init(2'h1, 1'b1);
    mac.q = '{6'h16, 6'h19, 6'h00};
    addBits(5'h06, 4);
    addBits(5'h09, 4);
    capTx("txSym", 1);
  endtask

  task automatic txMii10;
    init(2'h2, 1'b0);
    mac.q = '{6'h13, 6'h1C, 6'h00};
    addBits(5'h03, 4);
    addBits(5'h0C, 4);
    capTx("tx10", 10);
  endtask

  task automatic txSerial;
    init(2'h3, 1'b0);
    mac.q = '{6'h11, 6'h10, 6'h11, 6'h11, 6'h00};
    addBits(5'h0D, 4);
    capTx("txSer", 10);
  endtask

  task automatic rx100;
    init(2'h0, 1'b1);
    lineRx(16'h5A3C, 16, 1, 2);
    rxCheck({5'h05, 5'h1A, 5'h03, 5'h0C}, 4);
  endtask

  task automatic rx10;
    init(2'h2, 1'b1);
    lineRx(16'h005D, 8, 10, -1);
    rxCheck({10'h000, 5'h05, 5'h0D}, 2);
  endtask

  task automatic rxSerial;
    int f;
    init(2'h3, 1'b1);
    lineRx(16'h000D, 4, 10, -1);
    f = 0;
    while (f < sq.size() && !sq[f])
      f++;
    for (int i = 0; i < 4; i++)
      chk("serRx", 16'(sq[f + i]), 16'(i != 1));
  endtask

  task automatic mgmt;
    init(2'h2, 1'b1);
    mgmtRead(`PMI_PHY_ADDR_DEF);
    mgmtRead(5'h02);
    chk("mdioOther", rd, 16'hFFFF);
    mgmtRead(`PMI_PHY_ADDR_DEF);
    chk("mdioStatus", rd, 16'h0028);
  endtask

  initial
  begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    modeSel = 2'h0;
    fullDuplex = 1'b0;
    line_rx_pair = 1'b0;
    lineRxValid = 1'b0;
    lineRxError = 1'b0;
    mdc = 1'b0;
    staOe = 1'b0;
    staBit = 1'b1;
    rd = 16'h0000;
    txMii100();
    txSym100();
    txMii10();
    txSerial();
    rx100();
    rx10();
    rxSerial();
    mgmt();
    summarize();
  end

  initial
  begin
    #300000;
    errors++;
    summarize();
  end
endmodule
